// File: rtl/lcb_limit_bank.sv
// limit comparator bank with AXI4-Lite registers and one interrupt line
// assumes measurement inputs come from logic on aclk, refreshed by meas_update
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "lcb_regs.svh"

module lcb_limit_bank
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire lcb_pkg::lcb_val_t meas_gross, // measurement without zero offset
	input wire lcb_pkg::lcb_val_t zero_offset, // offset set by the zero command
	input wire lcb_pkg::lcb_val_t peak_max, // stored maximum
	input wire lcb_pkg::lcb_val_t peak_min, // stored minimum
	input wire logic meas_update, // one-cycle pulse, new measurement
	output logic [3:0] limit_lamp, // front panel indicators
	output logic [3:0] limit_line, // logic level output lines
	output logic [3:0] relay_drive, // relay coil drive, polarity applied
	output logic irq // level interrupt
);
	import lcb_pkg::*;

	// ==========================================================
	// helpers
	function automatic lcb_wide_t wide(input lcb_val_t v);
		wide = {{3{v[17]}}, v};
	endfunction : wide

	// saturate a written word into the legal figure range
	function automatic lcb_val_t clamp(input logic [31:0] raw, input logic unsigned_only);
		logic signed [31:0] s;
		s = $signed(raw);
		if (s > $signed({11'h000, `LCB_VAL_MAX}))
			clamp = lcb_val_t'(`LCB_VAL_MAX);
		else if (unsigned_only && s < 0)
			clamp = '0;
		else if (s < -$signed({11'h000, `LCB_VAL_MAX}))
			clamp = -lcb_val_t'(`LCB_VAL_MAX);
		else
			clamp = s[17:0];
	endfunction : clamp

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// ==========================================================
	// bus slave state
	logic fast;
	logic [31:0] stage_cfg;
	logic [31:0] stage_thresh;
	logic [31:0] stage_dev;
	logic [31:0] stage_hys;
	logic [4:0] int_status;
	logic [4:0] int_mask;
	logic [1:0] cursor;
	lcb_mode_e mode [0:3];
	lcb_source_e src [0:3];
	logic [3:0] latch_on;
	logic [3:0] relay_nc;
	logic [3:0] active;
	lcb_state_e state;
	logic [1:0] idx;

	logic wr_go;
	logic [7:0] wa;
	logic [31:0] wd;
	logic wr_hit;
	logic [1:0] last_limit;
	logic commit;
	logic restart;
	logic [3:0] clr_req;
	logic [4:0] w1c;

	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wa = {s_axi_awaddr[7:2], 2'b00};
	assign wd = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	assign last_limit = fast ? `LCB_LAST_FAST : `LCB_LAST_STD;
	assign commit = wr_go && wa == `LCB_ADDR_COMMIT && wd[`LCB_COMMIT_GO];
	assign restart = wr_go && wa == `LCB_ADDR_COMMIT && wd[`LCB_COMMIT_RESTART];
	assign clr_req = (wr_go && wa == `LCB_ADDR_LATCH_CLR) ? wd[3:0] : 4'h0;
	assign w1c = (wr_go && wa == `LCB_ADDR_INT_STATUS) ? wd[4:0] : 5'h00;

	always_comb
	begin
		case (wa)
			`LCB_ADDR_CTRL, `LCB_ADDR_CFG, `LCB_ADDR_THRESH, `LCB_ADDR_DEV, `LCB_ADDR_HYS,
			`LCB_ADDR_COMMIT, `LCB_ADDR_LATCH_CLR, `LCB_ADDR_STATE, `LCB_ADDR_INT_STATUS,
			`LCB_ADDR_INT_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// write channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LCB_RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `LCB_RESP_OKAY : `LCB_RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fast <= 1'b0;
			stage_cfg <= `LCB_ZERO32;
			stage_thresh <= `LCB_ZERO32;
			stage_dev <= `LCB_ZERO32;
			stage_hys <= `LCB_ZERO32;
			int_mask <= 5'h00;
		end
		else if (wr_go)
		begin
			case (wa)
				`LCB_ADDR_CTRL: fast <= s_axi_wstrb[0] ? s_axi_wdata[`LCB_CTRL_FAST] : fast;
				`LCB_ADDR_CFG: stage_cfg <= merge(stage_cfg, s_axi_wdata, s_axi_wstrb);
				`LCB_ADDR_THRESH: stage_thresh <= merge(stage_thresh, s_axi_wdata, s_axi_wstrb);
				`LCB_ADDR_DEV: stage_dev <= merge(stage_dev, s_axi_wdata, s_axi_wstrb);
				`LCB_ADDR_HYS: stage_hys <= merge(stage_hys, s_axi_wdata, s_axi_wstrb);
				`LCB_ADDR_INT_MASK: int_mask <= 5'(merge({27'h0, int_mask}, s_axi_wdata, s_axi_wstrb));
				default: ;
			endcase
		end
	end

	// ==========================================================
	// setup cursor and per-limit settings
	lcb_mode_e cmode;
	lcb_source_e csrc;
	logic mem_we;
	lcb_word_t mem_wdata;

	always_comb
	begin
		cmode = lcb_mode_e'(stage_cfg[`LCB_CFG_MODE]);
		if (fast && cmode == lcb_dev_mode)
			cmode = lcb_off_mode;
		csrc = (stage_cfg[`LCB_CFG_SRC] > 3'h5) ? lcb_net_source : lcb_source_e'(stage_cfg[`LCB_CFG_SRC]);
	end

	// off stores no figures, so its old ones are simply left unused
	assign mem_we = commit && cmode != lcb_off_mode;
	assign mem_wdata = {fast ? lcb_val_t'(0) : clamp(stage_hys, 1'b1),
		clamp(stage_dev, 1'b1), clamp(stage_thresh, 1'b0)};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cursor <= 2'h0;
		end
		else if (restart)
		begin
			cursor <= 2'h0;
		end
		else if (commit)
		begin
			cursor <= (cursor == last_limit) ? 2'h0 : cursor + 2'h1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
			begin
				mode[i] <= lcb_off_mode;
				src[i] <= lcb_net_source;
			end
			latch_on <= 4'h0;
			relay_nc <= 4'h0;
		end
		else if (commit && !restart)
		begin
			mode[cursor] <= cmode;
			src[cursor] <= csrc;
			latch_on[cursor] <= stage_cfg[`LCB_CFG_LATCH];
			relay_nc[cursor] <= stage_cfg[`LCB_CFG_NC];
		end
	end

	// ==========================================================
	// evaluation: one pass over the limits per measurement update
	lcb_word_t mem_rdata;
	lcb_val_t snap_gross;
	lcb_val_t snap_zero;
	lcb_val_t snap_max;
	lcb_val_t snap_min;
	lcb_wide_t val;
	lcb_wide_t sp;
	lcb_wide_t dev;
	lcb_wide_t hys;
	logic next_act;
	logic [3:0] act_set;

	lcb_limit_mem i_lcb_limit_mem
	(
		.aclk(aclk),
		.we(mem_we && !restart),
		.waddr(cursor),
		.wdata(mem_wdata),
		.raddr(idx),
		.rdata(mem_rdata)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= lcb_idle;
			idx <= 2'h0;
		end
		else
		begin
			case (state)
				lcb_idle:
				begin
					idx <= 2'h0;
					if (meas_update)
						state <= lcb_fetch;
				end
				lcb_fetch: state <= lcb_judge;
				lcb_judge:
				begin
					if (idx == 2'h3)
						state <= lcb_idle;
					else
					begin
						idx <= idx + 2'h1;
						state <= lcb_fetch;
					end
				end
				default: state <= lcb_idle;
			endcase
		end
	end

	// inputs are frozen for the pass so every limit sees the same sample
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			snap_gross <= '0;
			snap_zero <= '0;
			snap_max <= '0;
			snap_min <= '0;
		end
		else if (state == lcb_idle && meas_update)
		begin
			snap_gross <= meas_gross;
			snap_zero <= zero_offset;
			snap_max <= peak_max;
			snap_min <= peak_min;
		end
	end

	always_comb
	begin
		case (src[idx])
			lcb_net_source: val = wide(snap_gross) - wide(snap_zero);
			lcb_gross_source: val = wide(snap_gross);
			lcb_tare_source: val = wide(snap_zero);
			lcb_max_source: val = wide(snap_max);
			lcb_min_source: val = wide(snap_min);
			lcb_peak_to_peak_range: val = wide(snap_max) - wide(snap_min);
			default: val = wide(snap_gross) - wide(snap_zero);
		endcase
		sp = wide(mem_rdata[`LCB_MEM_SP]);
		dev = wide(mem_rdata[`LCB_MEM_DEV]);
		hys = wide(mem_rdata[`LCB_MEM_HYS]);
		next_act = 1'b0;
		case (mode[idx])
			lcb_high_mode: next_act = active[idx] ? !(val < sp - hys) : (val > sp);
			lcb_low_mode: next_act = active[idx] ? !(val > sp + hys) : (val < sp);
			lcb_dev_mode: next_act = !fast && (val > sp + dev || val < sp - dev);
			default: next_act = 1'b0;
		endcase
		if (idx > last_limit)
			next_act = 1'b0;
	end

	always_comb
	begin
		act_set = 4'h0;
		if (state == lcb_judge && next_act && !active[idx])
			act_set[idx] = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			active <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (state == lcb_judge && idx == 2'(i))
				begin
					// a latched limit leaves only through the clear, by being set to off or by lying beyond the last limit, and a fresh trip beats the clear
					if (latch_on[i] && active[i] && mode[i] != lcb_off_mode && !clr_req[i])
						active[i] <= 1'b1;
					else
						active[i] <= next_act;
				end
				else if (clr_req[i] || mode[i] == lcb_off_mode || 2'(i) > last_limit)
				begin
					active[i] <= 1'b0;
				end
			end
		end
	end

	// one state feeds lamp, line and relay so they never disagree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			limit_lamp <= 4'h0;
			limit_line <= 4'h0;
			relay_drive <= 4'h0;
		end
		else
		begin
			limit_lamp <= active;
			limit_line <= active;
			relay_drive <= active ^ relay_nc;
		end
	end

	// ==========================================================
	// interrupts and read channel
	logic done_evt;

	assign done_evt = commit && !restart && cursor == last_limit;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_status <= 5'h00;
		end
		else
		begin
			int_status <= (int_status & ~w1c) | {done_evt, act_set};
		end
	end

	assign irq = |(int_status & int_mask);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `LCB_ZERO32;
			s_axi_rresp <= `LCB_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `LCB_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				`LCB_ADDR_CTRL: s_axi_rdata <= {31'h0, fast};
				`LCB_ADDR_CFG: s_axi_rdata <= stage_cfg;
				`LCB_ADDR_THRESH: s_axi_rdata <= stage_thresh;
				`LCB_ADDR_DEV: s_axi_rdata <= stage_dev;
				`LCB_ADDR_HYS: s_axi_rdata <= stage_hys;
				`LCB_ADDR_COMMIT, `LCB_ADDR_LATCH_CLR: s_axi_rdata <= `LCB_ZERO32;
				`LCB_ADDR_STATE: s_axi_rdata <= {25'h0, state != lcb_idle, cursor, active};
				`LCB_ADDR_INT_STATUS: s_axi_rdata <= {27'h0, int_status};
				`LCB_ADDR_INT_MASK: s_axi_rdata <= {27'h0, int_mask};
				default:
				begin
					s_axi_rdata <= `LCB_ZERO32;
					s_axi_rresp <= `LCB_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : lcb_limit_bank
`default_nettype wire

// File: inc/lcb_regs.svh
// register map, field layout and fixed figures of the limit comparator bank
// assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word
`ifndef LCB_REGS_SVH
`define LCB_REGS_SVH

// ==========================================================
// register byte offsets
`define LCB_ADDR_CTRL 8'h00
`define LCB_ADDR_CFG 8'h04
`define LCB_ADDR_THRESH 8'h08
`define LCB_ADDR_DEV 8'h0C
`define LCB_ADDR_HYS 8'h10
`define LCB_ADDR_COMMIT 8'h14
`define LCB_ADDR_LATCH_CLR 8'h18
`define LCB_ADDR_STATE 8'h1C
`define LCB_ADDR_INT_STATUS 8'h20
`define LCB_ADDR_INT_MASK 8'h24

// ==========================================================
// fields
`define LCB_CTRL_FAST 0
`define LCB_CFG_MODE 1:0
`define LCB_CFG_SRC 4:2
`define LCB_CFG_LATCH 5
`define LCB_CFG_NC 6
`define LCB_COMMIT_GO 0
`define LCB_COMMIT_RESTART 1
`define LCB_STATE_ACTIVE 3:0
`define LCB_STATE_CURSOR 5:4
`define LCB_STATE_BUSY 6
`define LCB_INT_DONE 4
`define LCB_MEM_SP 17:0
`define LCB_MEM_DEV 35:18
`define LCB_MEM_HYS 53:36

// ==========================================================
// figures
`define LCB_VAL_MAX 21'h1_869F
`define LCB_LAST_STD 2'h3
`define LCB_LAST_FAST 2'h1
`define LCB_RESP_OKAY 2'h0
`define LCB_RESP_SLVERR 2'h2
`define LCB_ZERO32 32'h0000_0000

`endif

// File: inc/lcb_pkg.sv
// types shared by the limit comparator bank files
// assumes lcb_regs.svh is on the include path
`include "lcb_regs.svh"
package lcb_pkg;
	typedef logic signed [17:0] lcb_val_t;
	typedef logic signed [20:0] lcb_wide_t;
	typedef logic [53:0] lcb_word_t;
	typedef enum logic [1:0] {
		lcb_off_mode = 2'h0,
		lcb_high_mode = 2'h1,
		lcb_low_mode = 2'h2,
		lcb_dev_mode = 2'h3
	} lcb_mode_e;
	typedef enum logic [2:0] {
		lcb_net_source = 3'h0,
		lcb_gross_source = 3'h1,
		lcb_tare_source = 3'h2,
		lcb_max_source = 3'h3,
		lcb_min_source = 3'h4,
		lcb_peak_to_peak_range = 3'h5
	} lcb_source_e;
	typedef enum logic [1:0] {
		lcb_idle = 2'h0,
		lcb_fetch = 2'h1,
		lcb_judge = 2'h3
	} lcb_state_e;
endpackage : lcb_pkg

// File: rtl/lcb_limit_mem.sv
// per-limit set point, deviation and dead band store
// assumes one writer and one reader on the same clock; read data one cycle late
`timescale 1ns/1ns
`default_nettype none
module lcb_limit_mem
(
	input wire logic aclk, // system clock
	input wire logic we, // write strobe
	input wire logic [1:0] waddr, // limit written
	input wire lcb_pkg::lcb_word_t wdata, // packed limit figures
	input wire logic [1:0] raddr, // limit read
	output lcb_pkg::lcb_word_t rdata // registered read data
);
	import lcb_pkg::*;

	lcb_word_t mem [0:3];

	always_ff @(posedge aclk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge aclk)
	begin
		rdata <= mem[raddr];
	end
endmodule : lcb_limit_mem
`default_nettype wire

// File: tb/lcb_monitor.sv
// port checker for the limit comparator bank
// assumes the bank's top module ports; the bind after endmodule attaches it
`timescale 1ns/1ns
`default_nettype none
module lcb_monitor
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic s_axi_awvalid, // write address valid
	input wire logic s_axi_awready, // write address ready
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic meas_update, // new measurement pulse
	input wire logic [3:0] limit_lamp, // indicators
	input wire logic [3:0] limit_line, // logic lines
	input wire logic [3:0] relay_drive, // relay drive
	input wire logic irq // interrupt
);
	// ==========================================================
	// clocking
	default clocking mon_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// checks
	AST_LINE_FOLLOWS_LAMP: assert property (limit_line == limit_lamp)
		else $error("logic line differs from lamp");
	AST_QUIET_AFTER_RESET: assert property ($rose(aresetn) |-> limit_lamp == 4'h0 && !irq && !s_axi_rvalid)
		else $error("outputs not cleared by reset");
	AST_RELAY_OPEN_AFTER_RESET: assert property ($rose(aresetn) |-> relay_drive == 4'h0)
		else $error("relay not open after reset");
	// a lamp may only light as the result of a judged update, at its fixed slot
	AST_FIRST_LAMP_SLOT: assert property ($rose(limit_lamp[0]) |-> $past(meas_update, 4))
		else $error("limit 1 lit outside its slot");
	AST_LAST_LAMP_SLOT: assert property ($rose(limit_lamp[3]) |-> $past(meas_update, 10))
		else $error("limit 4 lit outside its slot");
	AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	AST_NO_WRITE_WHILE_B: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while response pending");
	AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	AST_NO_READ_WHILE_R: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule : lcb_monitor

bind lcb_limit_bank lcb_monitor i_lcb_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .meas_update, .limit_lamp,
	.limit_line, .relay_drive, .irq);
`default_nettype wire

// File: tb/lcb_panel_model.sv
// front panel model: lamps, logic lines and relay contacts of the limits
// assumes relay_drive already carries the polarity, 1 = contacts closed
`timescale 1ns/1ns
`default_nettype none
module lcb_panel_model
(
	input wire logic aclk, // system clock
	input wire logic [3:0] limit_lamp, // lamp drive
	input wire logic [3:0] limit_line, // logic output lines
	input wire logic [3:0] relay_drive, // relay coil drive
	output logic [3:0] lit, // lamps seen lit
	output logic [3:0] closed, // contacts seen closed
	output logic [3:0] line_seen // lines seen high
);
	// real contacts take milliseconds; one clock of lag stands in for that
	always_ff @(posedge aclk)
	begin
		lit <= limit_lamp;
		closed <= relay_drive;
		line_seen <= limit_line;
	end
endmodule : lcb_panel_model
`default_nettype wire

// File: tb/tb_top.sv
// testbench for the limit comparator bank: bus tasks, reference model, checks
// assumes lcb_pkg, the panel model and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "lcb_regs.svh"
module tb_top;
	import lcb_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b1;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic meas_update = 1'b0;
	lcb_val_t meas_gross = '0;
	lcb_val_t zero_offset = '0;
	lcb_val_t peak_max = '0;
	lcb_val_t peak_min = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] limit_lamp, limit_line, relay_drive, lit, closed, line_seen;
	logic [33:0] exp_q[$];
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [1:0] r_mode[4];
	logic [2:0] r_src[4];
	int r_sp[4], r_dev[4], r_hys[4];
	logic [3:0] r_lat, r_nc;
	logic [3:0] r_act = 4'h0;
	logic [4:0] r_int = 5'h00;
	logic [1:0] cur = 2'h0;
	logic fast = 1'b0;

	lcb_limit_bank i_lcb_limit_bank
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.meas_gross, .zero_offset, .peak_max, .peak_min, .meas_update, .limit_lamp, .limit_line,
		.relay_drive, .irq
	);
	lcb_panel_model i_lcb_panel_model
	(
		.aclk, .limit_lamp, .limit_line, .relay_drive, .lit, .closed, .line_seen
	);

	// ==========================================================
	// clock, watchdog, read result checker
	always #5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			close_out();
		end
	end
	always @(posedge aclk)
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());

	// ==========================================================
	// tasks
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_bvalid);
		chk({32'h0000_0000, s_axi_bresp}, {32'h0000_0000, resp});
	endtask : wr

	// rready comes one cycle late so the read data must stand while stalled
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic setup(input logic [1:0] m, input logic [2:0] s, input int sp, dv, hy, input logic lt, nc);
		wr(`LCB_ADDR_CFG, {25'h000_0000, nc, lt, s, m}, `LCB_RESP_OKAY);
		wr(`LCB_ADDR_THRESH, 32'(sp), `LCB_RESP_OKAY);
		wr(`LCB_ADDR_DEV, 32'(dv), `LCB_RESP_OKAY);
		wr(`LCB_ADDR_HYS, 32'(hy), `LCB_RESP_OKAY);
		wr(`LCB_ADDR_COMMIT, 32'h0000_0001, `LCB_RESP_OKAY);
		r_mode[cur] = (fast && m == lcb_dev_mode) ? lcb_off_mode : m;
		r_src[cur] = s;
		r_sp[cur] = sp > 99999 ? 99999 : (sp < -99999 ? -99999 : sp);
		r_dev[cur] = dv;
		r_hys[cur] = hy;
		r_lat[cur] = lt;
		r_nc[cur] = nc;
		cur = (cur == (fast ? 2'h1 : 2'h3)) ? 2'h0 : cur + 2'h1;
		if (cur == 2'h0)
			r_int[4] = 1'b1;
	endtask : setup

	function automatic logic judge(int i, int v);
		int h;
		logic c;
		h = fast ? 0 : r_hys[i];
		case (r_mode[i])
			lcb_high_mode: c = r_act[i] ? v >= r_sp[i] - h : v > r_sp[i];
			lcb_low_mode: c = r_act[i] ? v <= r_sp[i] + h : v < r_sp[i];
			lcb_dev_mode: c = v > r_sp[i] + r_dev[i] || v < r_sp[i] - r_dev[i];
			default: return 1'b0;
		endcase
		return c || (r_lat[i] && r_act[i]);
	endfunction : judge

	task automatic upd(input int g, input int z, input int mx, input int mn);
		int v;
		logic c;
		meas_gross <= lcb_val_t'(g);
		zero_offset <= lcb_val_t'(z);
		peak_max <= lcb_val_t'(mx);
		peak_min <= lcb_val_t'(mn);
		meas_update <= 1'b1;
		@(posedge aclk);
		meas_update <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			case (r_src[i])
				lcb_gross_source: v = g;
				lcb_tare_source: v = z;
				lcb_max_source: v = mx;
				lcb_min_source: v = mn;
				lcb_peak_to_peak_range: v = mx - mn;
				default: v = g - z;
			endcase
			c = i < (fast ? 2 : 4) && judge(i, v);
			r_int[i] = r_int[i] | (c & ~r_act[i]);
			r_act[i] = c;
		end
		repeat (12) @(posedge aclk);
		chk({30'h0, lit}, {30'h0, r_act});
		chk({30'h0, line_seen}, {30'h0, r_act});
		chk({30'h0, closed}, {30'h0, r_act ^ r_nc});
		rd(`LCB_ADDR_STATE, {28'h000_0000, cur, r_act});
	endtask : upd

	// ==========================================================
	// main sequence
	initial
	begin
		int g;
		void'($urandom(66756));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({30'h0, closed}, 34'h0);
		rd(`LCB_ADDR_CFG, 34'h0);
		rd(`LCB_ADDR_STATE, 34'h0);
		rd(`LCB_ADDR_CTRL, 34'h0);
		// byte lane 1 only: staging keeps its other bytes, the variant bit is untouched
		s_axi_wstrb <= 4'h2;
		wr(`LCB_ADDR_CFG, 32'hffff_ffff, `LCB_RESP_OKAY);
		wr(`LCB_ADDR_CTRL, 32'hffff_ffff, `LCB_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(`LCB_ADDR_CFG, 34'h0_0000_ff00);
		rd(`LCB_ADDR_CTRL, 34'h0);
		rd(8'h28, {`LCB_RESP_SLVERR, 32'h0000_0000});
		wr(8'h28, 32'h0000_0001, `LCB_RESP_SLVERR);
		setup(lcb_high_mode, lcb_net_source, 100, 0, 10, 1'b0, 1'b0);
		setup(lcb_low_mode, lcb_gross_source, -50, 0, 5, 1'b0, 1'b1);
		setup(lcb_dev_mode, lcb_tare_source, 100, 10, 0, 1'b0, 1'b0);
		setup(lcb_high_mode, lcb_peak_to_peak_range, 300, 0, 0, 1'b1, 1'b0);
		rd(`LCB_ADDR_INT_STATUS, {29'h0, r_int});
		chk({33'h0, irq}, 34'h0);
		upd(-51, -152, 0, 0);
		upd(-47, -142, 0, 0);
		upd(-44, -133, 0, 0);
		upd(0, 0, 500, 0);
		upd(0, 0, 0, 0);
		wr(`LCB_ADDR_LATCH_CLR, 32'h0000_0008, `LCB_RESP_OKAY);
		r_act[3] = 1'b0;
		rd(`LCB_ADDR_STATE, {28'h000_0000, cur, r_act});
		repeat (16)
		begin
			g = int'($urandom_range(400)) - 200;
			upd(g, 80 + int'($urandom_range(40)), int'($urandom_range(400)), int'($urandom_range(200)));
		end
		wr(`LCB_ADDR_INT_MASK, 32'h0000_001f, `LCB_RESP_OKAY);
		chk({33'h0, irq}, {33'h0, |r_int});
		rd(`LCB_ADDR_INT_STATUS, {29'h0, r_int});
		wr(`LCB_ADDR_INT_STATUS, 32'h0000_001f, `LCB_RESP_OKAY);
		r_int = 5'h00;
		chk({33'h0, irq}, 34'h0);
		upd(0, 100, 500, 0);
		wr(`LCB_ADDR_CTRL, 32'h0000_0001, `LCB_RESP_OKAY);
		fast = 1'b1;
		wr(`LCB_ADDR_COMMIT, 32'h0000_0002, `LCB_RESP_OKAY);
		cur = 2'h0;
		setup(lcb_dev_mode, lcb_min_source, 0, 5, 0, 1'b0, 1'b0);
		setup(lcb_high_mode, lcb_max_source, 200000, 0, 50, 1'b0, 1'b0);
		upd(0, 0, 99999, -100);
		upd(0, 0, 100000, -100);
		upd(0, 0, 99990, -100);
		wr(`LCB_ADDR_COMMIT, 32'h0000_0002, `LCB_RESP_OKAY);
		cur = 2'h0;
		setup(lcb_low_mode, lcb_min_source, -200000, 0, 5, 1'b0, 1'b1);
		upd(0, 0, 0, -99999);
		upd(0, 0, 0, -100000);
		upd(0, 0, 0, -99998);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
